// >>> include/dpb_pkg.sv
`default_nettype none
package dpb_pkg;

  // ***************************************************************
  // widths and counts
  // ***************************************************************
  localparam int WORD_W        = 18;
  localparam int WORD_W_NARROW = 18;
  localparam int WORD_W_WIDE   = 36;
  localparam int ADDR_W        = 20;
  localparam int BURST_LEN     = 4;
  localparam int FIFO_DEPTH    = 16;

  // ***************************************************************
  // echo clock levels per lane and reset values
  // ***************************************************************
  localparam logic [1:0] ECHO_RISE  = 2'h2;
  localparam logic [1:0] ECHO_FALL  = 2'h1;
  localparam logic [1:0] ECHO_RESET = 2'h0;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef logic [BURST_LEN-1:0][WORD_W-1:0] dpb_burst_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    dpb_burst_type     words;
  } dpb_wr_entry_type;

  typedef struct packed {
    logic [1:0]        echo;
    logic              valid;
    logic [WORD_W-1:0] data;
  } dpb_out_lane_type;

  localparam dpb_out_lane_type LANE_RESET = '{
    echo:  ECHO_RESET,
    valid: 1'b0,
    data:  '0
  };

  typedef enum logic {
    WR_IDLE,
    WR_SECOND
  } dpb_wr_state_type;

endpackage
`default_nettype wire

// >>> logic/dpb_wr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dpb_wr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int KEY_W = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  // newest-match search on the key held in the top bits
  input  wire logic [KEY_W-1:0] look_key,
  output logic                  look_hit,
  output logic      [WIDTH-1:0] look_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || KEY_W > WIDTH) begin : g_chk
    $error("fifo depth must be a power of two and key fit the word");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W:0]   count;
  logic [PTR_W-1:0] idx;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // walk oldest to newest so the newest match wins
  always_comb begin
    look_hit  = 1'b0;
    look_data = '0;
    idx       = '0;
    for (int i = 0; i < DEPTH; i++) begin
      idx = rd_ptr + PTR_W'(i);
      if ((PTR_W+1)'(i) < count &&
          store[idx][WIDTH-1 -: KEY_W] == look_key) begin
        look_hit  = 1'b1;
        look_data = store[idx];
      end
    end
  end

endmodule // dpb_wr_fifo
`default_nettype wire

// >>> logic/dpb_sram.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - separate read data outputs and write data inputs, no shared data bus
// - one address bus, read and write addresses taken on alternate edges
// - each address holds a burst of four words, 18 or 36 bits wide
// - data moves on every rising edge of both complementary clocks
// - latency select high: first read word two and a half cycles later
// - latency select low: first read word one cycle after the request
// - reads and writes proceed independently and may overlap
// - every synchronous input is caught in an input register first
// - every read output comes from an output register
// - captured writes reach the array by self-timed internal logic
// - separate read and write port selects enable or deselect each port
// - a valid flag marks each half cycle that carries read data
// - echo clock pair travels with the read data
// - reads return the newest data, including writes held in the buffer; a burst still being captured is missed
module dpb_sram #(
  parameter int FIFO_DEPTH = dpb_pkg::FIFO_DEPTH,
  parameter int MEM_ADDR_W = dpb_pkg::ADDR_W
) (
  // core clock, reset and enable
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  // core status
  output logic                              writes_pending,
  output logic                              write_lost,
  // link clock: its falling edge is the complement clock's rise
  input  wire logic                         link_clk,
  // address, port selects and mode pin
  input  wire logic [dpb_pkg::ADDR_W-1:0]   addr_pin,
  input  wire logic                         read_port_sel_n,
  input  wire logic                         write_port_sel_n,
  input  wire logic                         latency_select_pin,
  // write data pins
  input  wire logic [dpb_pkg::WORD_W-1:0]   write_data_pin,
  // read lanes for the output double-rate cell
  output var  dpb_pkg::dpb_out_lane_type    rise_lane,
  output var  dpb_pkg::dpb_out_lane_type    fall_lane
);
  import dpb_pkg::*;

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (WORD_W != WORD_W_NARROW && WORD_W != WORD_W_WIDE) begin : g_chk_w
    $error("word width must be 18 or 36");
  end
  if (MEM_ADDR_W < 1 || MEM_ADDR_W > ADDR_W) begin : g_chk_a
    $error("array address width out of range");
  end

  localparam int ENTRY_W = $bits(dpb_wr_entry_type);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [1:0]             link_rst_sync;
  logic                   link_rst_n;
  logic                   lat_meta;
  logic                   lat_long;
  logic                   en_meta;
  logic                   commit_en;
  logic                   rd_sel_q;
  logic [ADDR_W-1:0]      rd_addr_q;
  logic [WORD_W-1:0]      d_pos_q;
  logic                   wr_sel_q;
  logic [ADDR_W-1:0]      wr_addr_q;
  logic [WORD_W-1:0]      d_neg_q;
  logic                   rd_take;
  logic [3:1]             rd_sr;
  dpb_burst_type          lookup_words;
  dpb_burst_type          burst_a;
  dpb_burst_type          burst_b;
  dpb_wr_state_type       wr_state;
  dpb_wr_entry_type       wr_entry;
  logic                   wr_done;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [ENTRY_W-1:0]     fifo_out_raw;
  dpb_wr_entry_type       fifo_out;
  logic                   look_hit;
  logic [ENTRY_W-1:0]     look_raw;
  dpb_wr_entry_type       look_entry;
  logic                   lost_tgl;
  logic                   pend_meta;
  logic                   pend_sync;
  logic                   lost_meta;
  logic                   lost_sync;
  logic                   lost_seen;

  // the array itself
  dpb_burst_type          mem [2**MEM_ADDR_W];

  // ***************************************************************
  // link-side reset and synchronisers
  // ***************************************************************
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_sync <= 2'h0;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_sync[1];

  // mode pin is static in use, but still synchronised
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lat_meta <= 1'b0;
      lat_long <= 1'b0;
    end else begin
      lat_meta <= latency_select_pin;
      lat_long <= lat_meta;
    end
  end

  // on the link side core enable only stalls the commit engine; pins cannot be stalled
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      en_meta   <= 1'b0;
      commit_en <= 1'b0;
    end else begin
      en_meta   <= clk_en;
      commit_en <= en_meta;
    end
  end

  // ***************************************************************
  // input registers
  // ***************************************************************
  // write data pins only ever feed these input registers
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_sel_q  <= 1'b0;
      rd_addr_q <= '0;
      d_pos_q   <= '0;
    end else begin
      rd_sel_q  <= ~read_port_sel_n;
      rd_addr_q <= addr_pin;
      d_pos_q   <= write_data_pin;
    end
  end

  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wr_sel_q  <= 1'b0;
      wr_addr_q <= '0;
      d_neg_q   <= '0;
    end else begin
      wr_sel_q  <= ~write_port_sel_n;
      wr_addr_q <= addr_pin;
      d_neg_q   <= write_data_pin;
    end
  end

  // ***************************************************************
  // write capture
  // ***************************************************************
  // burst of four, one command per two cycles
  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wr_state <= WR_IDLE;
      wr_done  <= 1'b0;
    end else begin
      wr_done <= 1'b0;
      case (wr_state)
        WR_IDLE: begin
          if (wr_sel_q) begin
            wr_state <= WR_SECOND;
          end
        end
        WR_SECOND: begin
          wr_done  <= 1'b1;
          wr_state <= WR_IDLE;
        end
        default: begin
          wr_state <= WR_IDLE;
        end
      endcase
    end
  end

  // words alternate between complement and true edges
  always_ff @(negedge link_clk) begin
    if (wr_state == WR_IDLE && wr_sel_q) begin
      wr_entry.addr     <= wr_addr_q;
      wr_entry.words[0] <= d_neg_q;
      wr_entry.words[1] <= d_pos_q;
    end else if (wr_state == WR_SECOND) begin
      wr_entry.words[2] <= d_neg_q;
      wr_entry.words[3] <= d_pos_q;
    end
  end

  // ***************************************************************
  // write buffer and commit engine
  // ***************************************************************
  dpb_wr_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH),
    .KEY_W (ADDR_W)
  ) u_wr_fifo (
    .clk       (link_clk),
    .rst_n     (link_rst_n),
    .in_valid  (wr_done),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_entry),
    .out_valid (fifo_out_valid),
    .out_ready (commit_en),
    .out_data  (fifo_out_raw),
    .look_key  (rd_addr_q),
    .look_hit  (look_hit),
    .look_data (look_raw)
  );

  assign fifo_out   = fifo_out_raw;
  assign look_entry = look_raw;

  always_ff @(posedge link_clk) begin
    if (fifo_out_valid && commit_en) begin
      mem[fifo_out.addr[MEM_ADDR_W-1:0]] <= fifo_out.words;
    end
  end

  // a full buffer cannot refuse the pins, so the loss is reported
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lost_tgl <= 1'b0;
    end else if (wr_done && !fifo_in_ready) begin
      lost_tgl <= ~lost_tgl;
    end
  end

  // ***************************************************************
  // read request and lookup
  // ***************************************************************
  // a read right after a taken read is ignored
  assign rd_take = rd_sel_q & ~rd_sr[1];

  assign lookup_words = look_hit ? look_entry.words
                                 : mem[rd_addr_q[MEM_ADDR_W-1:0]];

  // read pipeline runs regardless of write activity
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_sr <= 3'h0;
    end else begin
      rd_sr <= {rd_sr[2:1], rd_take};
    end
  end

  always_ff @(posedge link_clk) begin
    if (rd_take) begin
      burst_a <= lookup_words;
    end
    if (rd_sr[1]) begin
      burst_b <= burst_a;
    end
  end

  // ***************************************************************
  // output lanes
  // ***************************************************************
  // true-edge lane
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rise_lane <= LANE_RESET;
    end else begin
      rise_lane.echo  <= ECHO_RISE;
      rise_lane.valid <= 1'b0;
      if (!lat_long && rd_take) begin
        rise_lane.valid <= 1'b1;
        rise_lane.data  <= lookup_words[0];
      end else if (!lat_long && rd_sr[1]) begin
        rise_lane.valid <= 1'b1;
        rise_lane.data  <= burst_a[2];
      end else if (lat_long && rd_sr[2]) begin
        rise_lane.valid <= 1'b1;
        rise_lane.data  <= burst_b[1];
      end else if (lat_long && rd_sr[3]) begin
        rise_lane.valid <= 1'b1;
        rise_lane.data  <= burst_b[3];
      end
    end
  end

  always_ff @(negedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fall_lane <= LANE_RESET;
    end else begin
      fall_lane.echo  <= ECHO_FALL;
      fall_lane.valid <= 1'b0;
      if (!lat_long && rd_sr[1]) begin
        fall_lane.valid <= 1'b1;
        fall_lane.data  <= burst_a[1];
      end else if (!lat_long && rd_sr[2]) begin
        fall_lane.valid <= 1'b1;
        fall_lane.data  <= burst_a[3];
      end else if (lat_long && rd_sr[2]) begin
        fall_lane.valid <= 1'b1;
        fall_lane.data  <= burst_b[0];
      end else if (lat_long && rd_sr[3]) begin
        fall_lane.valid <= 1'b1;
        fall_lane.data  <= burst_b[2];
      end
    end
  end

  // ***************************************************************
  // core-side status
  // ***************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_meta      <= 1'b0;
      pend_sync      <= 1'b0;
      writes_pending <= 1'b0;
    end else if (clk_en) begin
      pend_meta      <= fifo_out_valid;
      pend_sync      <= pend_meta;
      writes_pending <= pend_sync;
    end
  end

  // sticky until reset; two losses inside one sync window toggle back and may go unseen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lost_meta  <= 1'b0;
      lost_sync  <= 1'b0;
      lost_seen  <= 1'b0;
      write_lost <= 1'b0;
    end else if (clk_en) begin
      lost_meta  <= lost_tgl;
      lost_sync  <= lost_meta;
      lost_seen  <= lost_sync;
      write_lost <= write_lost | (lost_sync ^ lost_seen);
    end
  end

endmodule // dpb_sram
`default_nettype wire

// >>> bench/dpb_sram_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dpb_sram_sva (
  // clocks and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       link_clk,
  // core side
  input wire logic                       clk_en,
  input wire logic                       writes_pending,
  input wire logic                       write_lost,
  // link pins
  input wire logic                       read_port_sel_n,
  input wire logic                       latency_select_pin,
  input wire dpb_pkg::dpb_out_lane_type  rise_lane,
  input wire dpb_pkg::dpb_out_lane_type  fall_lane
);
  import dpb_pkg::*;
  // ****************************************
  // read latency and valid framing
  // ****************************************
  // lanes are seen one edge after they update
  property p_rd_lo_rise;
    @(posedge link_clk) disable iff (!rst_n)
      !read_port_sel_n && $past(read_port_sel_n) && !latency_select_pin
      |-> ##2 rise_lane.valid [*2] ##1 !rise_lane.valid;
  endproperty
  a_rd_lo_rise: assert property (p_rd_lo_rise) else $error("short read rise");
  property p_rd_lo_fall;
    @(posedge link_clk) disable iff (!rst_n)
      !read_port_sel_n && $past(read_port_sel_n) && !latency_select_pin
      |-> ##2 fall_lane.valid [*2] ##1 !fall_lane.valid;
  endproperty
  a_rd_lo_fall: assert property (p_rd_lo_fall) else $error("short read fall");
  property p_rd_hi_rise;
    @(posedge link_clk) disable iff (!rst_n)
      !read_port_sel_n && $past(read_port_sel_n) && latency_select_pin
      |-> ##4 rise_lane.valid [*2] ##1 !rise_lane.valid;
  endproperty
  a_rd_hi_rise: assert property (p_rd_hi_rise) else $error("long read rise");
  property p_rd_hi_fall;
    @(posedge link_clk) disable iff (!rst_n)
      !read_port_sel_n && $past(read_port_sel_n) && latency_select_pin
      |-> ##3 fall_lane.valid [*2] ##1 !fall_lane.valid;
  endproperty
  a_rd_hi_fall: assert property (p_rd_hi_fall) else $error("long read fall");
  property p_no_spurious;
    @(posedge link_clk) disable iff (!rst_n)
      rise_lane.valid |-> (latency_select_pin ?
        (!$past(read_port_sel_n, 4) || !$past(read_port_sel_n, 5)) :
        (!$past(read_port_sel_n, 2) || !$past(read_port_sel_n, 3)));
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("valid w/o read");
  // ****************************************
  // echo clocks and core status
  // ****************************************
  property p_echo_rise;
    @(posedge link_clk) disable iff (!rst_n)
      $past(rst_n, 4) |-> rise_lane.echo == ECHO_RISE;
  endproperty
  a_echo_rise: assert property (p_echo_rise) else $error("rise echo level");
  property p_echo_fall;
    @(posedge link_clk) disable iff (!rst_n)
      $past(rst_n, 4) |-> fall_lane.echo == ECHO_FALL;
  endproperty
  a_echo_fall: assert property (p_echo_fall) else $error("fall echo level");
  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      !clk_en |=> $stable(writes_pending) && $stable(write_lost);
  endproperty
  a_freeze: assert property (p_freeze) else $error("status moved");
  property p_lost_sticky;
    @(posedge clk) disable iff (!rst_n) write_lost |=> write_lost;
  endproperty
  a_lost_sticky: assert property (p_lost_sticky) else $error("lost cleared");
  c_rd_lo: cover property (@(posedge link_clk) disable iff (!rst_n)
    !read_port_sel_n && !latency_select_pin);
  c_rd_hi: cover property (@(posedge link_clk) disable iff (!rst_n)
    !read_port_sel_n && latency_select_pin);
  c_lost: cover property (@(posedge clk) disable iff (!rst_n) $rose(write_lost));
endmodule // dpb_sram_sva
`default_nettype wire

// >>> bench/dpb_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpb_ctrl_model (
  // link clock
  input  wire logic                    link_clk,
  // pins toward the memory
  output logic [dpb_pkg::ADDR_W-1:0]   addr_pin,
  output logic                         read_port_sel_n,
  output logic                         write_port_sel_n,
  output logic [dpb_pkg::WORD_W-1:0]   write_data_pin
);
  import dpb_pkg::*;
  initial begin
    addr_pin         = '0;
    read_port_sel_n  = 1'b1;
    write_port_sel_n = 1'b1;
    write_data_pin   = '0;
  end
  // ****************************************
  // one slot: read at k, write at next kn
  // ****************************************
  // unused lines never keep a stale value
  task automatic op(input logic rd, input logic [ADDR_W-1:0] ra,
                    input logic wr, input logic [ADDR_W-1:0] wa,
                    input dpb_burst_type w);
    @(posedge link_clk);
    read_port_sel_n  <= !rd;
    addr_pin         <= rd ? ra : ADDR_W'($urandom);
    write_data_pin   <= ~write_data_pin;
    @(posedge link_clk);
    read_port_sel_n  <= 1'b1;
    write_port_sel_n <= !wr;
    addr_pin         <= wr ? wa : ADDR_W'($urandom);
    write_data_pin   <= w[0];
    @(negedge link_clk);
    write_port_sel_n <= 1'b1;
    addr_pin         <= ADDR_W'($urandom);
    write_data_pin   <= w[1];
    @(posedge link_clk);
    write_data_pin   <= w[2];
    @(negedge link_clk);
    write_data_pin   <= w[3];
  endtask
endmodule // dpb_ctrl_model
`default_nettype wire

// >>> bench/test_dpb_sram.sv
`timescale 1ns/1ps
`default_nettype none
module test_dpb_sram;
  import dpb_pkg::*;
  localparam int N_ADDR = 16;
  logic                clk = 1'b0;
  logic                link_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                clk_en = 1'b1;
  logic                lat = 1'b0;
  logic [ADDR_W-1:0]   addr_pin;
  logic                rsel_n;
  logic                wsel_n;
  logic [WORD_W-1:0]   wdata;
  logic                writes_pending;
  logic                write_lost;
  dpb_out_lane_type    rise_lane;
  dpb_out_lane_type    fall_lane;
  dpb_burst_type       mem [N_ADDR];
  logic [WORD_W-1:0]   expq [$];
  int                  n_fail = 0;
  int                  checks = 0;
  int                  cyc = 0;
  logic [31:0]         seed;
  always #2 clk = ~clk;
  // odd offset keeps the two clocks unrelated
  initial begin
    #1.3;
    forever #40 link_clk = ~link_clk;
  end
  dpb_sram #(.FIFO_DEPTH(FIFO_DEPTH), .MEM_ADDR_W(4)) uut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .writes_pending(writes_pending), .write_lost(write_lost),
    .link_clk(link_clk), .addr_pin(addr_pin), .read_port_sel_n(rsel_n),
    .write_port_sel_n(wsel_n), .latency_select_pin(lat),
    .write_data_pin(wdata), .rise_lane(rise_lane), .fall_lane(fall_lane));
  dpb_ctrl_model ctrl (.link_clk(link_clk), .addr_pin(addr_pin),
    .read_port_sel_n(rsel_n), .write_port_sel_n(wsel_n),
    .write_data_pin(wdata));
  // ****************************************
  // checking
  // ****************************************
  task automatic cmp(input logic [WORD_W-1:0] got,
                     input logic [WORD_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic take(input dpb_out_lane_type l);
    logic [WORD_W-1:0] e;
    if (l.valid === 1'b1) begin
      if (expq.size() == 0) begin
        n_fail++;
        $display("MISMATCH t=%0t read data without a read", $time);
      end else begin
        e = expq.pop_front();
        cmp(l.data, e);
      end
    end
  endtask
  always @(posedge link_clk) begin
    #1;
    take(rise_lane);
  end
  always @(negedge link_clk) begin
    #1;
    take(fall_lane);
  end
  task automatic final_report;
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      final_report;
    end
  end
  // ****************************************
  // stimulus
  // ****************************************
  task automatic do_op(input logic rd, input int ra, input logic wr,
                       input int wa, input logic drop);
    dpb_burst_type w;
    w = dpb_burst_type'({$urandom, $urandom, $urandom});
    if (rd) for (int i = 0; i < BURST_LEN; i++) expq.push_back(mem[ra][i]);
    if (wr && !drop) mem[wa] = w;
    ctrl.op(rd, ADDR_W'(ra), wr, ADDR_W'(wa), w);
  endtask
  // link reset needs two link edges, so hold in link cycles
  task automatic do_reset(input logic l);
    @(posedge clk) rst_n <= 1'b0;
    lat <= l;
    repeat (8) @(posedge link_clk);
    @(posedge clk) rst_n <= 1'b1;
    repeat (6) @(posedge link_clk);
    cmp(WORD_W'(write_lost), '0);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge link_clk);
    while (writes_pending !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    cmp(WORD_W'(writes_pending), '0);
  endtask
  initial begin
    int wa;
    seed = $urandom(32'hfd3c6275);
    for (int l = 0; l < 2; l++) begin
      do_reset(l[0]);
      for (int a = 0; a < N_ADDR; a++) do_op(1'b0, 0, 1'b1, a, 1'b0);
      // read right behind its write, overlapping traffic
      for (int i = 0; i < 12; i++) begin
        wa = $urandom_range(15);
        do_op(1'b1, $urandom_range(15), 1'b1, wa, 1'b0);
        do_op(1'b1, wa, 1'($urandom_range(1)), $urandom_range(15), 1'b0);
      end
      wait_idle;
      // stall commits, fill the buffer past its depth
      @(posedge clk) clk_en <= 1'b0;
      repeat (4) @(posedge link_clk);
      for (int a = 0; a <= N_ADDR; a++)
        do_op(a > 0, (a + 15) % N_ADDR, 1'b1, a % N_ADDR, a == N_ADDR);
      @(posedge clk) clk_en <= 1'b1;
      repeat (40) @(posedge clk);
      cmp(WORD_W'(write_lost), WORD_W'(1));
      wait_idle;
      for (int a = 0; a < N_ADDR; a++) do_op(1'b1, a, 1'b0, 0, 1'b0);
      repeat (8) @(posedge link_clk);
      cmp(WORD_W'(expq.size()), '0);
    end
    final_report;
  end
endmodule // test_dpb_sram
bind dpb_sram dpb_sram_sva chk (.clk(clk), .rst_n(rst_n),
  .link_clk(link_clk), .clk_en(clk_en), .writes_pending(writes_pending),
  .write_lost(write_lost), .read_port_sel_n(read_port_sel_n),
  .latency_select_pin(latency_select_pin), .rise_lane(rise_lane),
  .fall_lane(fall_lane));
`default_nettype wire
